// File: hw/sfi_pkg.sv
// Package: constants and types for the serial frame converter interface
// Summary of operation
// R1 - Each conversion, sampling and shift-out together, takes exactly 16 serial clocks while chip select is low.
// R2 - Raising chip select at any point abandons the running conversion without needing the remaining clocks.
// R3 - The result leaves on the data pin most significant bit first, least significant bit last.
// R4 - Bits shifted in a frame belong to the conversion running in that frame, with no pipeline latency.
// R5 - With chip select still low after a conversion ends, the next conversion starts at once and repeats.
// R6 - The host captures each data bit on the rising clock edge after the falling edge that launched it.
// R7 - The sample rate is at most the serial clock over 16; the host may lower it by spacing frames.
// R8 - Acquisition ends and the input is held at the fourth falling clock edge of each conversion.
// R9 - The input is sampled onto the array at conversion start and kept isolated while converting.
// R10 - The data output is released after chip select rises so others may share the line.
// R11 - Each 16-bit word is four leading zeros then twelve result bits, each launched on a falling edge.
// R12 - The twelve result bits are a signed two's complement value of the differential input.
// R13 - The data output is driven only while chip select is low; chip select high means power-down.
// R14 - In continuous operation acquisition restarts after every sixteenth rising edge and conversion resumes at the fourth falling edge.
// R15 - The host keeps chip select low for whole words and drops the four leading zeros; the host model keeps them in rx_bits, and t_abort stops after 8 clocks.
package sfi_pkg;
    localparam int SAMPLE_WIDTH = 12;
    localparam int WORD_BITS = 16;
    localparam int LEAD_ZEROS = 4;
    localparam int HOLD_EDGE = 4;
    localparam int FIFO_DEPTH = 4;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;
    localparam logic [3:0] BIT_CNT_LAST = 4'hF;
    localparam logic [11:0] SAMPLE_RESET = 12'h000;

    typedef enum logic [2:0] {
        SFI_OFF = 3'b001,
        SFI_ACQ = 3'b010,
        SFI_CONV = 3'b100
    } sfi_state_type;

    // Link pins after synchronisation
    typedef struct packed {
        logic sel_n;
        logic sclk;
    } sfi_link_type;
endpackage

// File: hw/sfi_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
module sfi_fifo
    import sfi_pkg::*;
#(
    parameter int WIDTH = SAMPLE_WIDTH,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and control
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem_reg[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        mem_next = mem_reg;
        wr_next = wr_reg;
        rd_next = rd_reg;
        cnt_next = cnt_reg;
        if (push) begin
            mem_next[wr_reg] = in_data;
            wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
        end
        if (pop) begin
            rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
        end
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else if (ce) begin
            mem_reg <= mem_next;
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule

// File: hw/sfi_top.sv
// Serial frame interface of a 12-bit differential conversion engine
module sfi_top
    import sfi_pkg::*;
(
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // Conversion results from the array, signed two's complement
    input wire logic [SAMPLE_WIDTH-1:0] sample_data,
    input wire logic sample_valid,
    output logic sample_ready,
    // Serial link pins
    input wire logic sel_n,
    input wire logic sclk,
    output logic dout_o,
    output logic dout_oe,
    // Analog front-end control
    output logic track_en,
    output logic hold_strobe,
    output logic power_down
);
    logic rst_s1_reg, rst_s2_reg;
    logic sel_s1_reg, sel_s2_reg, sclk_s1_reg, sclk_s2_reg;
    sfi_link_type link;
    logic sclk_prev_reg, sel_prev_reg;
    logic fall_edge, rise_edge, frame_start;
    sfi_state_type state_reg, state_next;
    logic [3:0] fall_cnt_reg, fall_cnt_next;
    logic [3:0] rise_cnt_reg, rise_cnt_next;
    logic [SAMPLE_WIDTH-1:0] shift_reg, shift_next;
    logic dout_reg, dout_next, oe_reg, oe_next;
    logic track_reg, track_next, hold_reg, hold_next, pd_reg, pd_next;
    logic fifo_valid, fifo_take;
    logic [SAMPLE_WIDTH-1:0] fifo_data;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    // Two-stage synchronisers for the pins
    always_ff @(posedge mclk or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            sel_s1_reg <= 1'b1;
            sel_s2_reg <= 1'b1;
            sclk_s1_reg <= 1'b1;
            sclk_s2_reg <= 1'b1;
            sclk_prev_reg <= 1'b1;
            sel_prev_reg <= 1'b1;
        end else if (ce) begin
            sel_s1_reg <= sel_n;
            sel_s2_reg <= sel_s1_reg;
            sclk_s1_reg <= sclk;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_prev_reg <= sclk_s2_reg;
            sel_prev_reg <= sel_s2_reg;
        end
    end

    // Both members come from the second synchroniser stage only
    assign link = '{sel_n: sel_s2_reg, sclk: sclk_s2_reg};
    // Frame start with clock low counts as the first falling edge
    assign frame_start = sel_prev_reg && !link.sel_n;
    assign fall_edge = !link.sel_n &&
        ((sclk_prev_reg && !link.sclk) || (frame_start && !link.sclk));
    assign rise_edge = !link.sel_n && !sclk_prev_reg && link.sclk;

    sfi_fifo #(
        .WIDTH(SAMPLE_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(mclk),
        .rst_n(rst_s2_reg),
        .ce(ce),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .in_data(sample_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_take),
        .out_data(fifo_data)
    );

    // Last acquisition edge; pop and state change must agree on it
    function automatic logic hold_edge_due(input logic [3:0] cnt);
        return cnt == 4'(HOLD_EDGE - 1);
    endfunction

    // Result for the running word is taken at the fourth falling edge;
    // one pop per sixteen clocks caps the sample rate
    assign fifo_take = fall_edge && state_reg == SFI_ACQ &&
        hold_edge_due(fall_cnt_reg); // [R4] [R7]

    always_comb begin
        state_next = state_reg;
        fall_cnt_next = fall_cnt_reg;
        rise_cnt_next = rise_cnt_reg;
        shift_next = shift_reg;
        dout_next = dout_reg;
        oe_next = !link.sel_n; // [R13]
        pd_next = link.sel_n; // [R13]
        track_next = track_reg;
        hold_next = 1'b0;
        if (link.sel_n) begin
            // Abandon the word and release the line [R2] [R10]
            state_next = SFI_OFF;
            fall_cnt_next = BIT_CNT_RESET;
            rise_cnt_next = BIT_CNT_RESET;
            track_next = 1'b0;
            dout_next = 1'b0;
        end else begin
            if (rise_edge) begin
                rise_cnt_next = rise_cnt_reg + 1'b1; // [R1]
            end
            if (fall_edge) begin
                fall_cnt_next = fall_cnt_reg + 1'b1; // [R1]
                case (state_reg)
                    SFI_OFF: begin
                        state_next = SFI_ACQ;
                        track_next = 1'b1; // [R9]
                        dout_next = 1'b0; // [R11]
                    end
                    SFI_ACQ: begin
                        dout_next = 1'b0; // [R11]
                        if (hold_edge_due(fall_cnt_reg)) begin
                            state_next = SFI_CONV;
                            track_next = 1'b0; // [R8] [R9]
                            hold_next = 1'b1; // [R8]
                            shift_next = fifo_valid ? fifo_data
                                : SAMPLE_RESET; // [R12]
                        end
                    end
                    SFI_CONV: begin
                        if (fall_cnt_reg == BIT_CNT_RESET) begin
                            // Fall after the sixteenth rise opens the next
                            // word; the LSB stood until here [R5] [R14]
                            state_next = SFI_ACQ;
                            track_next = 1'b1; // [R9]
                            dout_next = 1'b0; // [R11]
                        end else begin
                            // Result MSB first on edges five to sixteen [R3]
                            dout_next = shift_reg[SAMPLE_WIDTH-1];
                            shift_next = {shift_reg[SAMPLE_WIDTH-2:0], 1'b0};
                        end
                    end
                    default: begin
                        state_next = SFI_OFF;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            state_reg <= SFI_OFF;
            fall_cnt_reg <= BIT_CNT_RESET;
            rise_cnt_reg <= BIT_CNT_RESET;
            shift_reg <= SAMPLE_RESET;
            dout_reg <= 1'b0;
            oe_reg <= 1'b0;
            pd_reg <= 1'b1;
            track_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            fall_cnt_reg <= fall_cnt_next;
            rise_cnt_reg <= rise_cnt_next;
            shift_reg <= shift_next;
            dout_reg <= dout_next;
            oe_reg <= oe_next;
            pd_reg <= pd_next;
            track_reg <= track_next;
            hold_reg <= hold_next;
        end
    end

    assign dout_o = dout_reg;
    assign dout_oe = oe_reg;
    assign track_en = track_reg;
    assign hold_strobe = hold_reg;
    assign power_down = pd_reg;

    // Protocol checks on the registered outputs and the word counters
    a_oe_follows_sel: assert property (@(posedge mclk) // [R13]
        disable iff (!rst_s2_reg)
        ce |=> dout_oe == !$past(link.sel_n))
        else $error("output enable does not follow chip select");

    a_pd_follows_sel: assert property (@(posedge mclk) // [R13]
        disable iff (!rst_s2_reg)
        ce |=> power_down == $past(link.sel_n))
        else $error("power down does not follow chip select");

    a_release_after_sel: assert property (@(posedge mclk) // [R10]
        disable iff (!rst_s2_reg)
        (ce && link.sel_n) |=> !dout_oe && state_reg == SFI_OFF)
        else $error("line not released after chip select high");

    a_dout_quiet: assert property (@(posedge mclk) // [R10]
        disable iff (!rst_s2_reg)
        !dout_oe |-> !dout_o)
        else $error("data bit left up on a released line");

    a_hold_on_fourth: assert property (@(posedge mclk) // [R8]
        disable iff (!rst_s2_reg)
        hold_strobe |-> fall_cnt_reg == 4'(HOLD_EDGE))
        else $error("hold not at the fourth falling edge");

    a_hold_single: assert property (@(posedge mclk) // [R8]
        disable iff (!rst_s2_reg)
        (ce && hold_strobe) |=> !hold_strobe)
        else $error("hold strobe longer than one cycle");

    a_hold_ends_track: assert property (@(posedge mclk) // [R8] [R9]
        disable iff (!rst_s2_reg)
        hold_strobe |-> !track_en)
        else $error("tracking still on at hold");

    a_take_on_hold: assert property (@(posedge mclk) // [R4]
        disable iff (!rst_s2_reg)
        (ce && fifo_take) |=> hold_strobe && state_reg == SFI_CONV)
        else $error("result taken away from the hold edge");

    a_lead_zeros: assert property (@(posedge mclk) // [R11]
        disable iff (!rst_s2_reg)
        (state_reg != SFI_CONV && dout_oe) |-> !dout_o)
        else $error("leading bit is not zero");

    a_lead_count: assert property (@(posedge mclk) // [R11]
        disable iff (!rst_s2_reg)
        (ce && fall_edge && state_reg != SFI_CONV) |=> !dout_o)
        else $error("leading fall launched a one");

    a_acq_count: assert property (@(posedge mclk) // [R8] [R14]
        disable iff (!rst_s2_reg)
        state_reg == SFI_ACQ |-> fall_cnt_reg != BIT_CNT_RESET
            && fall_cnt_reg <= 4'(HOLD_EDGE - 1))
        else $error("acquisition outside falls one to three");

    a_conv_count: assert property (@(posedge mclk) // [R1]
        disable iff (!rst_s2_reg)
        state_reg == SFI_CONV |-> fall_cnt_reg >= 4'(HOLD_EDGE)
            || fall_cnt_reg == BIT_CNT_RESET)
        else $error("conversion outside falls four to sixteen");

    a_word_wraps: assert property (@(posedge mclk) // [R1] [R14]
        disable iff (!rst_s2_reg)
        (ce && fall_edge && state_reg == SFI_CONV
         && fall_cnt_reg == BIT_CNT_LAST)
        |=> state_reg == SFI_CONV && fall_cnt_reg == BIT_CNT_RESET
            && !track_en)
        else $error("word did not wrap after sixteen edges");

    a_next_word: assert property (@(posedge mclk) // [R5] [R14]
        disable iff (!rst_s2_reg)
        (ce && fall_edge && state_reg == SFI_CONV
         && fall_cnt_reg == BIT_CNT_RESET)
        |=> state_reg == SFI_ACQ && track_en && !dout_o)
        else $error("next word did not start after sixteen rises");

    a_rise_count: assert property (@(posedge mclk) // [R1] [R14]
        disable iff (!rst_s2_reg)
        (ce && fall_edge && state_reg == SFI_CONV)
        |-> rise_cnt_reg == fall_cnt_reg)
        else $error("rising and falling edge counts disagree");

    a_first_fall_track: assert property (@(posedge mclk) // [R9]
        disable iff (!rst_s2_reg)
        (ce && fall_edge && state_reg == SFI_OFF)
        |=> state_reg == SFI_ACQ && track_en)
        else $error("first fall did not start acquisition");

    a_msb_first: assert property (@(posedge mclk) // [R3]
        disable iff (!rst_s2_reg)
        (ce && fall_edge && state_reg == SFI_CONV)
        |=> dout_o == $past(shift_reg[SAMPLE_WIDTH-1]))
        else $error("bit order is not MSB first");

    a_abandon_frame: assert property (@(posedge mclk) // [R2]
        disable iff (!rst_s2_reg)
        (ce && link.sel_n) |=> fall_cnt_reg == BIT_CNT_RESET
            && !track_en)
        else $error("conversion not abandoned");

    a_isolate_convert: assert property (@(posedge mclk) // [R9]
        disable iff (!rst_s2_reg)
        state_reg == SFI_CONV |-> !track_en)
        else $error("input tracked during conversion");

    a_state_onehot: assert property (@(posedge mclk)
        disable iff (!rst_s2_reg)
        $onehot(state_reg))
        else $error("state register is not one-hot");

    // A low enable must hold the word position and the data bit
    a_freeze_state: assert property (@(posedge mclk)
        disable iff (!rst_s2_reg)
        !ce |=> $stable(state_reg) && $stable(fall_cnt_reg)
            && $stable(dout_o))
        else $error("state moved while the clock enable was low");
endmodule

// File: sim/sfi_host.sv
// Host serial controller model: frames, serial clock and bit capture
module sfi_host (
    // Frame control from the bench
    input wire logic go,
    input wire logic [7:0] n_falls,
    output logic busy,
    output logic [63:0] rx_bits,
    output logic [7:0] rx_count,
    // Link pins
    output logic sel_n,
    output logic sclk,
    input wire logic dout_line
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sel_n = 1'b1;
        sclk = 1'b1;
        busy = 1'b0;
        rx_bits = '0;
        rx_count = '0;
    end

    // Clock stands high between frames; odd offset keeps it off mclk phase
    always @(posedge go) begin
        busy = 1'b1;
        rx_bits = '0;
        rx_count = '0;
        #7 sel_n = 1'b0;
        #160;
        repeat (n_falls) begin
            sclk = 1'b0;
            #160 sclk = 1'b1;
            // Bit launched on the fall is taken on the rise that follows
            rx_bits = {rx_bits[62:0], dout_line};
            rx_count = rx_count + 8'h01;
            #160;
        end
        sel_n = 1'b1;
        #320 busy = 1'b0;
    end
endmodule

// File: sim/testbench.sv
// Self-checking bench for the serial frame interface
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import sfi_pkg::*;

    logic mclk = 1'b0, rst_n = 1'b0, ce = 1'b1, go = 1'b0, last_drv = 1'b0;
    logic sample_valid = 1'b0, sample_ready, sel_n, sclk, dout_o, dout_oe;
    logic track_en, hold_strobe, power_down, busy, dout_line;
    logic [SAMPLE_WIDTH-1:0] sample_data = 12'h000;
    logic [7:0] n_falls = 8'h00, rx_count;
    logic [63:0] rx_bits;
    int num_errors = 0, samples_checked = 0, holds_seen = 0;

    always #20 mclk = ~mclk;

    // Released line shows no stale value
    always @(posedge mclk) if (dout_oe) last_drv <= dout_o;
    assign dout_line = dout_oe ? dout_o : ~last_drv;
    always @(posedge mclk) if (hold_strobe === 1'b1) holds_seen++;

    sfi_top dut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
        .sample_data(sample_data), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .sel_n(sel_n), .sclk(sclk),
        .dout_o(dout_o), .dout_oe(dout_oe), .track_en(track_en),
        .hold_strobe(hold_strobe), .power_down(power_down));

    sfi_host host (.go(go), .n_falls(n_falls), .busy(busy),
        .rx_bits(rx_bits), .rx_count(rx_count), .sel_n(sel_n),
        .sclk(sclk), .dout_line(dout_line));

    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic push(input logic [11:0] d);
        @(negedge mclk);
        check("ready", sample_ready, 1'b1);
        sample_valid = 1'b1;
        sample_data = d;
        @(negedge mclk);
        sample_valid = 1'b0;
    endtask

    task automatic frame(input logic [7:0] n);
        int i;
        @(negedge mclk);
        n_falls = n;
        go = 1'b1;
        @(negedge mclk);
        go = 1'b0;
        repeat (60) @(negedge mclk);
        check("oe in frame", dout_oe, 1'b1);
        check("powered", power_down, 1'b0);
        check("holding", track_en, 1'b0);
        i = 0;
        while (busy !== 1'b0 && i < 10000) begin
            @(negedge mclk);
            i++;
        end
        check("frame done", i < 10000, 1'b1);
        check("oe released", dout_oe, 1'b0);
        check("power down", power_down, 1'b1);
        check("clocks", rx_count, n);
    endtask

    task automatic t_reset;
        check("oe reset", dout_oe, 1'b0);
        check("pd reset", power_down, 1'b1);
        check("track reset", track_en, 1'b0);
    endtask

    task automatic t_single;
        holds_seen = 0;
        push(12'hA5C);
        frame(8'd16);
        check("word", rx_bits, 64'h0A5C);
        check("holds", holds_seen, 1);
    endtask

    task automatic t_cont;
        holds_seen = 0;
        push(12'h7FF);
        push(12'h800);
        push(12'h001);
        frame(8'd48);
        check("words", rx_bits, 64'h07FF_0800_0001);
        check("holds", holds_seen, 3);
    endtask

    task automatic t_abort;
        push(12'h123);
        frame(8'd8);
        check("short", rx_bits, 64'h01);
        push(12'h456);
        frame(8'd16);
        check("after short", rx_bits, 64'h0456);
    endtask

    task automatic t_fifo;
        push(12'hE01);
        push(12'hE02);
        push(12'hE03);
        push(12'hE04);
        @(negedge mclk);
        check("full", sample_ready, 1'b0);
        sample_valid = 1'b1;
        sample_data = 12'hBAD;
        @(negedge mclk);
        sample_valid = 1'b0;
        frame(8'd64);
        check("drain", rx_bits, 64'h0E01_0E02_0E03_0E04);
        frame(8'd16);
        check("empty", rx_bits, 64'h0);
    endtask

    task automatic t_freeze;
        @(negedge mclk);
        ce = 1'b0;
        sample_valid = 1'b1;
        sample_data = 12'h3C3;
        repeat (3) @(negedge mclk);
        sample_valid = 1'b0;
        ce = 1'b1;
        frame(8'd16);
        check("frozen push", rx_bits, 64'h0);
    endtask

    task automatic results;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(negedge mclk);
        rst_n = 1'b1;
        repeat (5) @(negedge mclk);
        t_reset();
        t_single();
        t_cont();
        t_abort();
        t_fifo();
        t_freeze();
        results();
    end

    initial begin
        #400000;
        num_errors++;
        results();
    end
endmodule
